// *** logic/pif_regs.svh ***
`ifndef PIF_REGS_SVH
`define PIF_REGS_SVH

// Byte addresses of the register window
// Flag register index; its byte address is four times the index
`define PIF_IDX_FLAGS 8'h0D
`define PIF_ADDR_FLAGS 8'h34
`define PIF_ADDR_IRQ_STAT 8'h10
`define PIF_ADDR_IRQ_EN 8'h14
`define PIF_ADDR_IRQ_CLR 8'h18
`define PIF_ADDR_WIDTH 8

// Flag register layout
`define PIF_BIT_CCP 0
`define PIF_BIT_BCL 3
`define PIF_BIT_EE 4
`define PIF_BIT_RSV 6
`define PIF_IMPL_MASK 8'h59
`define PIF_RESET_FLAGS 8'h00

// Interrupt status layout
`define PIF_NUM_EVENTS 3
`define PIF_EV_EE 0
`define PIF_EV_BCL 1
`define PIF_EV_CCP 2
`define PIF_RESET_EV 3'h0

// AHB encodings
`define PIF_HTRANS_NONSEQ 2'h2
`define PIF_HTRANS_SEQ 2'h3

`endif

// *** logic/pif_pkg.sv ***
package pif_pkg;
  typedef enum logic [1:0] {
    PIF_CC_OFF,
    PIF_CC_CAPTURE,
    PIF_CC_COMPARE,
    PIF_CC_PWM
  } pif_ccmode_e;
  typedef logic [7:0] pif_byte_t;
endpackage

// *** logic/pif_sync.sv ***
`timescale 1ns/1ps
module pif_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stageOne;

  initial begin
    if (WIDTH < 1) $error("pif_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stageOne <= '0;
      synced <= '0;
    end else begin
      stageOne <= async;
      synced <= stageOne;
    end
  end
endmodule

// *** logic/pif_flags.sv ***
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "pif_regs.svh"
module pif_flags (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic eepromWriteDone,
  input wire logic busCollision,
  input wire logic i2cMasterMode,
  input wire pif_pkg::pif_ccmode_e capcompMode,
  input wire logic timerCapture,
  input wire logic timerCompareMatch,
  input wire logic globalIrqEnable,
  input wire logic eventIrqEnable,
  output logic irq
);
  import pif_pkg::*;

  // ****************************************
  // Event inputs
  // ****************************************
  logic eeSync;
  logic bclSync;
  logic capSync;
  logic cmpSync;
  logic eeLast;
  logic bclLast;
  logic capLast;
  logic cmpLast;

  pif_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async({eepromWriteDone, busCollision, timerCapture, timerCompareMatch}),
    .synced({eeSync, bclSync, capSync, cmpSync})
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      eeLast <= 1'b0;
      bclLast <= 1'b0;
      capLast <= 1'b0;
      cmpLast <= 1'b0;
    end else begin
      eeLast <= eeSync;
      bclLast <= bclSync;
      capLast <= capSync;
      cmpLast <= cmpSync;
    end
  end

  wire eeEvent = eeSync & ~eeLast;
  wire bclEvent = bclSync & ~bclLast & i2cMasterMode;
  wire capEvent = capSync & ~capLast & (capcompMode == PIF_CC_CAPTURE);
  wire cmpEvent = cmpSync & ~cmpLast & (capcompMode == PIF_CC_COMPARE);
  wire ccEvent = capEvent | cmpEvent;

  // ****************************************
  // Bus slave
  // ****************************************
  logic dataPhase;
  logic phaseWrite;
  logic [`PIF_ADDR_WIDTH-1:0] phaseAddr;

  wire transferReq = hsel & hready & htrans[1];
  wire wordAccess = (hsize == 3'h2);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dataPhase <= 1'b0;
      phaseWrite <= 1'b0;
      phaseAddr <= '0;
    end else begin
      dataPhase <= transferReq;
      phaseWrite <= hwrite & wordAccess;
      phaseAddr <= haddr[`PIF_ADDR_WIDTH-1:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire wrEnable = dataPhase & phaseWrite;
  wire wrFlags = wrEnable & (phaseAddr == `PIF_ADDR_FLAGS);
  wire wrIrqEn = wrEnable & (phaseAddr == `PIF_ADDR_IRQ_EN);
  wire wrIrqClr = wrEnable & (phaseAddr == `PIF_ADDR_IRQ_CLR);
  wire rdFlags = transferReq & ~hwrite & (haddr[`PIF_ADDR_WIDTH-1:0] == `PIF_ADDR_FLAGS);
  wire rdStat = transferReq & ~hwrite & (haddr[`PIF_ADDR_WIDTH-1:0] == `PIF_ADDR_IRQ_STAT);
  wire rdEn = transferReq & ~hwrite & (haddr[`PIF_ADDR_WIDTH-1:0] == `PIF_ADDR_IRQ_EN);

  // ****************************************
  // Flag register
  // ****************************************
  pif_byte_t flags;
  pif_byte_t next_flags;
  wire [7:0] setMask = ({7'h00, ccEvent} << `PIF_BIT_CCP)
    | ({7'h00, bclEvent} << `PIF_BIT_BCL)
    | ({7'h00, eeEvent} << `PIF_BIT_EE);
  wire [7:0] writeVal = hwdata[7:0] & `PIF_IMPL_MASK;
  wire [7:0] heldVal = wrFlags ? writeVal : flags;

  assign next_flags = (heldVal | setMask) & `PIF_IMPL_MASK;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flags <= `PIF_RESET_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  // ****************************************
  // Interrupt status, enable, clear
  // ****************************************
  logic [`PIF_NUM_EVENTS-1:0] irqStat;
  logic [`PIF_NUM_EVENTS-1:0] irqEn;
  wire [`PIF_NUM_EVENTS-1:0] evVec;
  assign evVec[`PIF_EV_EE] = eeEvent;
  assign evVec[`PIF_EV_BCL] = bclEvent;
  assign evVec[`PIF_EV_CCP] = ccEvent;
  wire [`PIF_NUM_EVENTS-1:0] clrVec = wrIrqClr ? hwdata[`PIF_NUM_EVENTS-1:0] : '0;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      irqStat <= `PIF_RESET_EV;
      irqEn <= `PIF_RESET_EV;
    end else begin
      irqStat <= (irqStat & ~clrVec) | evVec;
      if (wrIrqEn) begin
        irqEn <= hwdata[`PIF_NUM_EVENTS-1:0];
      end
    end
  end

  // Peripheral gating by the global enables as well
  assign irq = |(irqStat & irqEn) & globalIrqEnable & eventIrqEnable;

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rdFlags) begin
      hrdata <= {24'h000000, next_flags};
    end else if (rdStat) begin
      hrdata <= {29'h0, irqStat};
    end else if (rdEn) begin
      hrdata <= {29'h0, irqEn};
    end else if (transferReq) begin
      hrdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_ee_sets;
    @(posedge clk_sys) disable iff (!resetn)
      eeEvent |=> flags[`PIF_BIT_EE];
  endproperty
  a_ee_sets: assert property (p_ee_sets) else $error("ee flag not set");

  property p_bcl_sets;
    @(posedge clk_sys) disable iff (!resetn)
      bclEvent |=> flags[`PIF_BIT_BCL];
  endproperty
  a_bcl_sets: assert property (p_bcl_sets) else $error("bcl flag not set");

  property p_bcl_only_master;
    @(posedge clk_sys) disable iff (!resetn)
      (!i2cMasterMode && !wrFlags && !flags[`PIF_BIT_BCL]) |=> !flags[`PIF_BIT_BCL];
  endproperty
  a_bcl_only_master: assert property (p_bcl_only_master) else $error("bcl set");

  property p_cap_sets;
    @(posedge clk_sys) disable iff (!resetn)
      capEvent |=> flags[`PIF_BIT_CCP];
  endproperty
  a_cap_sets: assert property (p_cap_sets) else $error("capture flag not set");

  property p_cmp_sets;
    @(posedge clk_sys) disable iff (!resetn)
      cmpEvent |=> flags[`PIF_BIT_CCP];
  endproperty
  a_cmp_sets: assert property (p_cmp_sets) else $error("compare flag not set");

  property p_unimpl_zero;
    @(posedge clk_sys) disable iff (!resetn)
      (flags & ~`PIF_IMPL_MASK) == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  property p_sticky;
    @(posedge clk_sys) disable iff (!resetn)
      (flags[`PIF_BIT_EE] && !wrFlags) |=> flags[`PIF_BIT_EE];
  endproperty
  a_sticky: assert property (p_sticky) else $error("ee flag dropped");

  property p_reset_clear;
    @(posedge clk_sys) !resetn |=> flags == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset not clear");

  sequence s_clear_and_set;
    wrFlags && !hwdata[`PIF_BIT_EE] && eeEvent;
  endsequence
  property p_set_wins;
    @(posedge clk_sys) disable iff (!resetn)
      s_clear_and_set |=> flags[`PIF_BIT_EE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

  property p_enable_free;
    @(posedge clk_sys) disable iff (!resetn)
      (eeEvent && !globalIrqEnable && !irqEn[`PIF_EV_EE]) |=> flags[`PIF_BIT_EE];
  endproperty
  a_enable_free: assert property (p_enable_free) else $error("flag gated");

  property p_read_addr;
    @(posedge clk_sys) disable iff (!resetn)
      rdFlags |=> hrdata == {24'h000000, flags};
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("bad flag read");

  // ****************************************
  // Further checks
  // ****************************************
  property p_pwm_no_cc;
    @(posedge clk_sys) disable iff (!resetn)
      (capcompMode == PIF_CC_PWM && !wrFlags && !flags[`PIF_BIT_CCP]) |=> !flags[`PIF_BIT_CCP];
  endproperty
  a_pwm_no_cc: assert property (p_pwm_no_cc) else $error("capcomp flag set in pwm");

  property p_off_no_cc;
    @(posedge clk_sys) disable iff (!resetn)
      (capcompMode == PIF_CC_OFF && !wrFlags && !flags[`PIF_BIT_CCP]) |=> !flags[`PIF_BIT_CCP];
  endproperty
  a_off_no_cc: assert property (p_off_no_cc) else $error("capcomp flag set when off");

  property p_unimpl_read;
    @(posedge clk_sys) disable iff (!resetn)
      rdFlags |=> (hrdata[31:8] == 24'h000000) && ((hrdata[7:0] & ~`PIF_IMPL_MASK) == 8'h00);
  endproperty
  a_unimpl_read: assert property (p_unimpl_read) else $error("unimplemented bit read");

  property p_write_masked;
    @(posedge clk_sys) disable iff (!resetn)
      (wrFlags && setMask == 8'h00) |=> flags == ($past(hwdata[7:0]) & `PIF_IMPL_MASK);
  endproperty
  a_write_masked: assert property (p_write_masked) else $error("flag write wrong");

  property p_clear_flag;
    @(posedge clk_sys) disable iff (!resetn)
      (wrFlags && !hwdata[`PIF_BIT_EE] && !eeEvent) |=> !flags[`PIF_BIT_EE];
  endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("ee flag not cleared");

  property p_ee_no_spurious;
    @(posedge clk_sys) disable iff (!resetn)
      (!eeEvent && !wrFlags && !flags[`PIF_BIT_EE]) |=> !flags[`PIF_BIT_EE];
  endproperty
  a_ee_no_spurious: assert property (p_ee_no_spurious) else $error("ee flag spurious");

  property p_bcl_sticky;
    @(posedge clk_sys) disable iff (!resetn)
      (flags[`PIF_BIT_BCL] && !wrFlags) |=> flags[`PIF_BIT_BCL];
  endproperty
  a_bcl_sticky: assert property (p_bcl_sticky) else $error("bcl flag dropped");

  property p_ccp_sticky;
    @(posedge clk_sys) disable iff (!resetn)
      (flags[`PIF_BIT_CCP] && !wrFlags) |=> flags[`PIF_BIT_CCP];
  endproperty
  a_ccp_sticky: assert property (p_ccp_sticky) else $error("capcomp flag dropped");

  property p_stat_set_wins;
    @(posedge clk_sys) disable iff (!resetn)
      (evVec[`PIF_EV_EE] && clrVec[`PIF_EV_EE]) |=> irqStat[`PIF_EV_EE];
  endproperty
  a_stat_set_wins: assert property (p_stat_set_wins) else $error("status set lost");

  property p_reset_read;
    @(posedge clk_sys) !resetn |=> hrdata == 32'h0000_0000;
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("read data not reset");

  property p_reset_stat;
    @(posedge clk_sys) !resetn |=> (irqStat == `PIF_RESET_EV) && (irqEn == `PIF_RESET_EV);
  endproperty
  a_reset_stat: assert property (p_reset_stat) else $error("status not reset");

  property p_okay;
    @(posedge clk_sys) disable iff (!resetn)
      hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");

  sequence s_narrow_write;
    transferReq && hwrite && !wordAccess;
  endsequence
  property p_narrow_ignored;
    @(posedge clk_sys) disable iff (!resetn)
      s_narrow_write ##1 (setMask == 8'h00) |=> $stable(flags);
  endproperty
  a_narrow_ignored: assert property (p_narrow_ignored) else $error("narrow write landed");
endmodule

// *** bench/tb_pif_flags.sv ***
`timescale 1ns/1ps
`include "pif_regs.svh"
module tb_pif_flags;
  import pif_pkg::*;
  // ****************
  // Stimulus signals
  // ****************
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] ev = 4'h0;
  logic i2c = 1'b0;
  pif_ccmode_e mode = PIF_CC_OFF;
  logic gGlob = 1'b0;
  logic gEv = 1'b0;
  logic irq;
  int errors = 0;
  int compares = 0;

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  pif_flags pif_flags_inst (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .eepromWriteDone(ev[0]),
    .busCollision(ev[1]), .i2cMasterMode(i2c), .capcompMode(mode), .timerCapture(ev[2]),
    .timerCompareMatch(ev[3]), .globalIrqEnable(gGlob), .eventIrqEnable(gEv), .irq(irq));

  // ****************
  // Tasks
  // ****************
  task automatic tally_and_finish();
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chkReg(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkIrq(input logic exp);
    compares++;
    if (irq !== exp) begin
      errors++;
      $display("[ERR] irq expected %b seen %b", exp, irq);
    end
  endtask

  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (hreadyout !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= `PIF_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    q = hrdata;
    chkReg("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chkReg(what, exp, q);
  endtask

  task automatic fire(input logic [3:0] m);
    ev <= m;
    repeat (2) @(posedge clk_sys);
    ev <= 4'h0;
    repeat (5) @(posedge clk_sys);
  endtask

  function automatic logic [7:0] expFlags(pif_ccmode_e m, logic i, logic [3:0] e);
    logic [7:0] f;
    f = 8'h00;
    f[`PIF_BIT_EE] = e[0];
    f[`PIF_BIT_BCL] = e[1] & i;
    f[`PIF_BIT_CCP] = (m == PIF_CC_CAPTURE && e[2]) || (m == PIF_CC_COMPARE && e[3]);
    return f;
  endfunction

  // ****************
  // Main sequence
  // ****************
  initial begin
    #(25ns * 100000);
    errors++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] r;
    logic [7:0] f;
    logic [2:0] st;
    pif_ccmode_e m;
    void'($urandom(32'hc6906c60));
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rdChk("flags", `PIF_ADDR_FLAGS, 32'h0);
    rdChk("status", `PIF_ADDR_IRQ_STAT, 32'h0);
    rdChk("unmapped", 8'h1C, 32'h0);
    wr(`PIF_ADDR_FLAGS, 32'hFFFF_FFBF);
    rdChk("flags", `PIF_ADDR_FLAGS, 32'h19);
    for (int k = 0; k < 16; k++) begin
      r = $urandom;
      m = (k < 4) ? pif_ccmode_e'(k[1:0]) : pif_ccmode_e'(r[1:0]);
      if (k < 4) r[6:3] = 4'hF;
      mode <= m;
      i2c <= r[2];
      gGlob <= r[10];
      gEv <= r[11];
      wr(`PIF_ADDR_IRQ_CLR, 32'h7);
      wr(`PIF_ADDR_IRQ_EN, {29'h0, r[9:7]});
      wr(`PIF_ADDR_FLAGS, 32'h0);
      fire(r[6:3]);
      f = expFlags(m, r[2], r[6:3]);
      st = {f[`PIF_BIT_CCP], f[`PIF_BIT_BCL], f[`PIF_BIT_EE]};
      rdChk("flags", `PIF_ADDR_FLAGS, {24'h0, f});
      rdChk("status", `PIF_ADDR_IRQ_STAT, {29'h0, st});
      rdChk("enable", `PIF_ADDR_IRQ_EN, {29'h0, r[9:7]});
      #1 chkIrq(|(st & r[9:7]) & r[10] & r[11]);
    end
    gGlob <= 1'b1;
    gEv <= 1'b1;
    wr(`PIF_ADDR_IRQ_EN, 32'h7);
    wr(`PIF_ADDR_IRQ_CLR, 32'h7);
    wr(`PIF_ADDR_FLAGS, 32'h0);
    fire(4'h1);
    #1 chkIrq(1'b1);
    wr(`PIF_ADDR_IRQ_CLR, 32'h7);
    #1 chkIrq(1'b0);
    rdChk("clear", `PIF_ADDR_IRQ_CLR, 32'h0);
    rdChk("flags", `PIF_ADDR_FLAGS, 32'h10);
    wr(`PIF_ADDR_FLAGS, 32'h0);
    ev <= 4'h1;
    @(posedge clk_sys);
    ev <= 4'h0;
    wr(`PIF_ADDR_FLAGS, 32'h0);
    rdChk("flags", `PIF_ADDR_FLAGS, 32'h10);
    tally_and_finish();
  end
endmodule
